// *** cevc_pkg.sv ***
/*
 * Constants for the core event controller: event levels, register map,
 * privilege encodings and reset values.
 * Assumes a single 10 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
package cevc_pkg;
	// Core clock period
	localparam int CLK_PERIOD_NS = 100;
	// Event count and level numbers
	localparam int NUM_LEVELS = 16;
	localparam logic [4:0] LVL_NONE = 5'h10;
	localparam logic [3:0] LVL_EMU = 4'h0;
	localparam logic [3:0] LVL_RESET = 4'h1;
	localparam logic [3:0] LVL_NMI = 4'h2;
	localparam logic [3:0] LVL_EXC = 4'h3;
	localparam logic [3:0] LVL_RSVD = 4'h4;
	localparam logic [3:0] LVL_HWERR = 4'h5;
	localparam logic [3:0] LVL_TIMER = 4'h6;
	localparam int GEN_FIRST = 7;
	localparam int NUM_GEN = 9;
	// Bits of the enable mask that software may change; levels 0-3 always enabled
	localparam logic [15:0] MASK_WRITABLE = 16'hffe0;
	localparam logic [15:0] MASK_FIXED_ON = 16'h000f;
	localparam logic [15:0] MASK_RESET = 16'h000f;
	// Register byte addresses
	localparam logic [7:0] ADDR_LATCH = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_NEST = 8'h08;
	localparam logic [7:0] ADDR_RAISE = 8'h0c;
	localparam logic [7:0] ADDR_CTRL = 8'h10;
	// Control register fields
	localparam int CTRL_GIE_BIT = 0;
	localparam int CTRL_MODE_LSB = 4;
	localparam logic CTRL_GIE_RESET = 1'b1;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// Privilege levels of the core
	typedef enum logic [1:0] {
		CEVC_USER = 2'h0,
		CEVC_SUPER = 2'h1,
		CEVC_EMUL = 2'h2
	} cevc_priv_t;
	localparam cevc_priv_t PRIV_RESET = CEVC_SUPER;
endpackage : cevc_pkg

// *** cevc_core_event_ctrl.sv ***
/*
 * Core event controller: latches sixteen prioritised events, nests their
 * handlers, tracks privilege level and serves its registers over AXI4-Lite.
 * Assumes event pins asynchronous, core handshake signals on clk, and that
 * the system interrupt router drives the nine general request lines.
 */
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
module cevc_core_event_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic emulationReq,
	input wire logic resetReq,
	input wire logic nmiPin,
	input wire logic watchdogNmi,
	input wire logic misalignReq,
	input wire logic undefinedReq,
	input wire logic hwErrorReq,
	input wire logic coreTimerReq,
	input wire logic [8:0] generalIrq,
	input wire logic coreReady,
	input wire logic [31:0] returnPc,
	input wire logic eventReturn,
	output logic takeValid,
	output logic [3:0] takeLevel,
	output logic saveState,
	output logic coreResetPulse,
	output logic resumeValid,
	output logic [31:0] resumePc,
	output logic [1:0] privLevel,
	output logic [15:0] nestOut,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [15:0] latchReg, latchNext, maskReg, nestReg, nestNext;
	logic [15:0] sync1Reg, sync2Reg, sync3Reg, rawEv, edgeVec, setVec, maskEff, pendVec;
	logic [15:0] swSet, swClr, takeOneHot, retOneHot, byteMask;
	logic [31:0] retAddrMem [cevc_pkg::NUM_LEVELS];
	logic [4:0] candLvl, topLvl;
	logic takeFire, gieReg, excReq;
	cevc_pkg::cevc_priv_t privReg;
	logic [7:0] awAddrReg;
	logic [31:0] wDataReg;
	logic [3:0] wStrbReg;
	logic awHeld, wHeld, wrDo, wrOk, arFire, rdOk;

	// Lowest set bit of a level vector, LVL_NONE when empty
	function automatic logic [4:0] lowestLvl(input logic [15:0] v);
		lowestLvl = cevc_pkg::LVL_NONE;
		for (int i = cevc_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
			if (v[i]) begin
				lowestLvl = 5'(i);
			end
		end
	endfunction : lowestLvl

	assign rawEv = {generalIrq, coreTimerReq, hwErrorReq, 2'b00, nmiPin | watchdogNmi, resetReq, emulationReq};

	// Two-flop synchroniser plus edge stage
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1Reg <= 16'h0000;
			sync2Reg <= 16'h0000;
			sync3Reg <= 16'h0000;
		end else begin
			sync1Reg <= rawEv;
			sync2Reg <= sync1Reg;
			sync3Reg <= sync2Reg;
		end
	end

	assign edgeVec = sync2Reg & ~sync3Reg;
	assign excReq = misalignReq | undefinedReq;
	assign setVec = (edgeVec | swSet | ({15'h0000, excReq} << cevc_pkg::LVL_EXC)) & ~(16'h0001 << cevc_pkg::LVL_RSVD);
	assign maskEff = ((maskReg & cevc_pkg::MASK_WRITABLE) | cevc_pkg::MASK_FIXED_ON)
		& {{cevc_pkg::NUM_GEN{gieReg}}, 7'h7f};
	assign pendVec = latchReg & maskEff;
	assign candLvl = lowestLvl(pendVec);
	assign topLvl = lowestLvl(nestReg);
	assign takeFire = coreReady && !eventReturn && (candLvl < topLvl);
	assign takeOneHot = takeFire ? (16'h0001 << candLvl[3:0]) : 16'h0000;
	assign retOneHot = (eventReturn && topLvl != cevc_pkg::LVL_NONE) ? (16'h0001 << topLvl[3:0]) : 16'h0000;

	always_comb begin
		latchNext = ((latchReg & ~takeOneHot & ~swClr) | setVec);
		nestNext = (nestReg & ~retOneHot) | takeOneHot;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			latchReg <= 16'h0000;
			nestReg <= 16'h0000;
		end else begin
			latchReg <= latchNext;
			nestReg <= nestNext;
		end
	end

	// Take outputs toward the sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			takeValid <= 1'b0;
			takeLevel <= 4'h0;
			saveState <= 1'b0;
			coreResetPulse <= 1'b0;
		end else begin
			takeValid <= takeFire;
			takeLevel <= takeFire ? candLvl[3:0] : takeLevel;
			saveState <= takeFire;
			coreResetPulse <= takeFire && candLvl[3:0] == cevc_pkg::LVL_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (takeFire) begin
			retAddrMem[candLvl[3:0]] <= returnPc;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			resumeValid <= 1'b0;
			resumePc <= 32'h00000000;
		end else begin
			resumeValid <= retOneHot != 16'h0000;
			resumePc <= (retOneHot != 16'h0000) ? retAddrMem[topLvl[3:0]] : resumePc;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			privReg <= cevc_pkg::PRIV_RESET;
		end else if (takeFire) begin
			privReg <= (candLvl[3:0] == cevc_pkg::LVL_EMU) ? cevc_pkg::CEVC_EMUL : cevc_pkg::CEVC_SUPER;
		end else if (retOneHot != 16'h0000) begin
			if (nestNext == 16'h0000) begin
				privReg <= cevc_pkg::CEVC_USER;
			end else if (nestNext[cevc_pkg::LVL_EMU]) begin
				privReg <= cevc_pkg::CEVC_EMUL;
			end else begin
				privReg <= cevc_pkg::CEVC_SUPER;
			end
		end
	end

	// Nest state and privilege also go out for acknowledgement
	always_ff @(posedge clk) begin
		if (rst) begin
			nestOut <= 16'h0000;
			privLevel <= cevc_pkg::PRIV_RESET;
		end else begin
			nestOut <= nestNext;
			privLevel <= privReg;
		end
	end

	// Write address and data capture, either order
	assign wrDo = awHeld && wHeld && !s_axi_bvalid;
	assign wrOk = privReg != cevc_pkg::CEVC_USER;
	assign byteMask = {{8{wStrbReg[1]}}, {8{wStrbReg[0]}}};
	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrReg <= 8'h00;
			wDataReg <= 32'h00000000;
			wStrbReg <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= cevc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddrReg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wDataReg <= s_axi_wdata;
				wStrbReg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wrDo) begin
				s_axi_bvalid <= 1'b1;
				if (!wrOk) begin
					s_axi_bresp <= cevc_pkg::RESP_SLVERR;
				end else if (awAddrReg == cevc_pkg::ADDR_LATCH || awAddrReg == cevc_pkg::ADDR_MASK
					|| awAddrReg == cevc_pkg::ADDR_NEST || awAddrReg == cevc_pkg::ADDR_RAISE
					|| awAddrReg == cevc_pkg::ADDR_CTRL) begin
					s_axi_bresp <= cevc_pkg::RESP_OKAY;
				end else begin
					s_axi_bresp <= cevc_pkg::RESP_DECERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// software raise; latch writable only where disabled
	always_comb begin
		swSet = 16'h0000;
		swClr = 16'h0000;
		if (wrDo && wrOk && awAddrReg == cevc_pkg::ADDR_RAISE) begin
			swSet = wDataReg[15:0] & byteMask & cevc_pkg::MASK_WRITABLE;
		end else if (wrDo && wrOk && awAddrReg == cevc_pkg::ADDR_LATCH) begin
			swSet = wDataReg[15:0] & byteMask & ~maskEff;
			swClr = ~wDataReg[15:0] & byteMask & ~maskEff;
		end
	end

	// Enable mask and global general-interrupt enable
	always_ff @(posedge clk) begin
		if (rst) begin
			maskReg <= cevc_pkg::MASK_RESET;
			gieReg <= cevc_pkg::CTRL_GIE_RESET;
		end else if (wrDo && wrOk) begin
			if (awAddrReg == cevc_pkg::ADDR_MASK) begin
				maskReg <= (maskReg & ~byteMask) | (wDataReg[15:0] & byteMask);
			end
			if (awAddrReg == cevc_pkg::ADDR_CTRL && wStrbReg[0]) begin
				gieReg <= wDataReg[cevc_pkg::CTRL_GIE_BIT];
			end
		end
	end

	// Read channel: one request, answer next cycle
	assign arFire = s_axi_arvalid && s_axi_arready;
	assign rdOk = privReg != cevc_pkg::CEVC_USER;
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= cevc_pkg::RESP_OKAY;
		end else if (arFire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= cevc_pkg::RESP_OKAY;
			if (!rdOk) begin
				s_axi_rresp <= cevc_pkg::RESP_SLVERR;
			end else begin
				unique case (s_axi_araddr)
					cevc_pkg::ADDR_LATCH: s_axi_rdata <= {16'h0000, latchReg};
					cevc_pkg::ADDR_MASK: s_axi_rdata <= {16'h0000, maskEff};
					cevc_pkg::ADDR_NEST: s_axi_rdata <= {16'h0000, nestReg};
					cevc_pkg::ADDR_RAISE: s_axi_rdata <= 32'h00000000;
					cevc_pkg::ADDR_CTRL: s_axi_rdata <= {26'h0000000, privReg, 3'h0, gieReg};
					default: s_axi_rresp <= cevc_pkg::RESP_DECERR;
				endcase
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Checks on the design's own behaviour
	property p_rsvdNever;
		@(posedge clk) disable iff (rst) !latchReg[4] && !nestReg[4];
	endproperty
	a_rsvdNever: assert property (p_rsvdNever) else $error("reserved level raised");
	property p_preempt;
		@(posedge clk) disable iff (rst) takeValid |-> ({1'b0, takeLevel} < $past(topLvl));
	endproperty
	a_preempt: assert property (p_preempt) else $error("take did not outrank active level");
	property p_lowestFirst;
		@(posedge clk) disable iff (rst) takeValid |-> $past(candLvl) == {1'b0, takeLevel};
	endproperty
	a_lowestFirst: assert property (p_lowestFirst) else $error("take not lowest pending level");
	property p_edgeLatch;
		@(posedge clk) disable iff (rst) $rose(sync2Reg[7]) |=> latchReg[7] || nestReg[7];
	endproperty
	a_edgeLatch: assert property (p_edgeLatch) else $error("edge not latched");
	property p_maskGate;
		@(posedge clk) disable iff (rst) takeValid |-> (($past(maskEff & latchReg) >> takeLevel) & 16'h0001) != 16'h0000;
	endproperty
	a_maskGate: assert property (p_maskGate) else $error("disabled event taken");
	property p_emuLevel;
		@(posedge clk) disable iff (rst) takeValid && takeLevel == 4'h0 |-> privReg == cevc_pkg::CEVC_EMUL;
	endproperty
	a_emuLevel: assert property (p_emuLevel) else $error("emulation take without emulation level");
	property p_resetTake;
		@(posedge clk) disable iff (rst) takeValid && takeLevel == 4'h1 |-> coreResetPulse ##1 !coreResetPulse;
	endproperty
	a_resetTake: assert property (p_resetTake) else $error("reset take without reset pulse");
	property p_userRead;
		@(posedge clk) disable iff (rst) arFire && privReg == cevc_pkg::CEVC_USER |=> s_axi_rresp == 2'h2;
	endproperty
	a_userRead: assert property (p_userRead) else $error("user read not refused");
	property p_minLatency;
		@(posedge clk) disable iff (rst) $rose(generalIrq[0]) && !nestReg[7] && !latchReg[7] |-> !nestReg[7][*3];
	endproperty
	a_minLatency: assert property (p_minLatency) else $error("nest bit set too early");
	property p_nestTake;
		@(posedge clk) disable iff (rst) takeValid |-> nestReg[takeLevel] && saveState;
	endproperty
	a_nestTake: assert property (p_nestTake) else $error("take without nest or save");
	c_nested: cover property (@(posedge clk) disable iff (rst) takeValid && $countones(nestReg) > 1);
	c_emuTake: cover property (@(posedge clk) disable iff (rst) takeValid && takeLevel == 4'h0);
	c_userRefuse: cover property (@(posedge clk) disable iff (rst) s_axi_bvalid && s_axi_bresp == 2'h2);
	c_resume: cover property (@(posedge clk) disable iff (rst) resumeValid);
endmodule : cevc_core_event_ctrl

// *** cevc_irq_router.sv ***
/* Model of the system interrupt router that feeds the nine general lines.
   Assumes the bench drives peripheral and software requests on clk. */
`timescale 1ns/1ns
module cevc_irq_router (
	input wire logic clk,
	input wire logic rst,
	input wire logic [6:0] periphReq,
	input wire logic [1:0] softReq,
	output logic [8:0] generalIrq
);
	// route onto general lines
	// Peripherals land on levels 7-13, software requests on 14-15
	always_ff @(posedge clk) begin
		if (rst) begin
			generalIrq <= 9'h000;
		end else begin
			generalIrq <= {softReq, periphReq};
		end
	end
endmodule : cevc_irq_router

// *** testbench.sv ***
/* Self-checking bench for the core event controller.
   Assumes the router model drives the general request lines. */
`timescale 1ns/1ns
module testbench;
	logic clk = 1'b0, rst = 1'b1, coreReady = 1'b1, eventReturn = 1'b0;
	logic [16:0] ev = 17'h00000;
	logic [31:0] returnPc = 32'h0, wdata = 32'h0, pcAt [16];
	logic [8:0] generalIrq, pick;
	logic takeValid, saveState, coreResetPulse, resumeValid;
	logic [3:0] takeLevel, wstrb = 4'hf;
	logic [31:0] resumePc, rdata;
	logic [1:0] privLevel, bresp, rresp;
	logic [15:0] nestOut;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	int miscompares = 0, checkCount = 0, seed = 32'ha50f, n;
	int srcs [8] = '{0, 1, 2, 16, 3, 4, 5, 6};
	int lvs [8] = '{0, 1, 2, 2, 3, 3, 5, 6};
	// Clock generation
	always #50 clk = ~clk;
	cevc_irq_router router (.clk(clk), .rst(rst), .periphReq(ev[13:7]), .softReq(ev[15:14]),
		.generalIrq(generalIrq));
	cevc_core_event_ctrl DUT (.clk(clk), .rst(rst), .emulationReq(ev[0]), .resetReq(ev[1]),
		.nmiPin(ev[2]), .watchdogNmi(ev[16]), .misalignReq(ev[3]), .undefinedReq(ev[4]),
		.hwErrorReq(ev[5]), .coreTimerReq(ev[6]), .generalIrq(generalIrq), .coreReady(coreReady),
		.returnPc(returnPc), .eventReturn(eventReturn), .takeValid(takeValid), .takeLevel(takeLevel),
		.saveState(saveState), .coreResetPulse(coreResetPulse), .resumeValid(resumeValid),
		.resumePc(resumePc), .privLevel(privLevel), .nestOut(nestOut), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	// Verdict and end of run
	task automatic test_done;
		if (miscompares == 0 && checkCount > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done
	task automatic hang;
		miscompares++;
		test_done;
	endtask : hang
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Register write, address and data offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		if (i == 20) hang;
		bready <= 1'b0;
		chk("bresp", bresp, er);
	endtask : axw
	// Register read; data compared only on an accepted access
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		if (i == 20) hang;
		rready <= 1'b0;
		chk("rresp", rresp, er);
		if (er == cevc_pkg::RESP_OKAY) chk("rdata", rdata, ed);
	endtask : axr
	// One-cycle request on the chosen event sources
	task automatic fire(input logic [16:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 17'h00000;
	endtask : fire
	// Wait for a take and check what comes with it
	task automatic waitTake(input int lv);
		for (n = 1; n < 40; n++) begin
			@(posedge clk);
			if (takeValid === 1'b1) break;
		end
		if (n == 40) hang;
		chk("takeLevel", takeLevel, lv);
		chk("saveState", saveState, 1'b1);
		chk("coreResetPulse", coreResetPulse, lv == 1);
		pcAt[lv] = returnPc;
		returnPc <= $random(seed);
		@(posedge clk);
		chk("privLevel", privLevel, lv == 0 ? 2 : 1);
	endtask : waitTake
	task automatic ret(input int lv);
		@(posedge clk);
		eventReturn <= 1'b1;
		@(posedge clk);
		eventReturn <= 1'b0;
		@(posedge clk);
		chk("resumeValid", resumeValid, 1'b1);
		chk("resumePc", resumePc, pcAt[lv]);
	endtask : ret
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("privLevel", privLevel, 1);
		chk("nestOut", nestOut, 0);
		axr(cevc_pkg::ADDR_MASK, 32'h000f, cevc_pkg::RESP_OKAY);
		axw(cevc_pkg::ADDR_MASK, 32'hffff, cevc_pkg::RESP_OKAY);
		axr(cevc_pkg::ADDR_MASK, 32'hffef, cevc_pkg::RESP_OKAY);
		axr(8'h20, 32'h0, cevc_pkg::RESP_DECERR);
		axr(cevc_pkg::ADDR_CTRL, 32'h0011, cevc_pkg::RESP_OKAY);
		coreReady <= 1'b0;
		axw(cevc_pkg::ADDR_MASK, 32'h000f, cevc_pkg::RESP_OKAY);
		fire(17'h00040);
		repeat (8) @(posedge clk);
		axr(cevc_pkg::ADDR_LATCH, 32'h0040, cevc_pkg::RESP_OKAY);
		axw(cevc_pkg::ADDR_RAISE, 32'h8000, cevc_pkg::RESP_OKAY);
		axr(cevc_pkg::ADDR_LATCH, 32'h8040, cevc_pkg::RESP_OKAY);
		axw(cevc_pkg::ADDR_MASK, 32'hffe0, cevc_pkg::RESP_OKAY);
		coreReady <= 1'b1;
		waitTake(6);
		fire(17'h00001);
		waitTake(0);
		chk("nestOut", nestOut, 16'h0041);
		ret(0);
		ret(6);
		waitTake(15);
		ret(15);
		@(posedge clk);
		chk("privLevel", privLevel, 0);
		axr(cevc_pkg::ADDR_MASK, 32'h0, cevc_pkg::RESP_SLVERR);
		// Every dedicated source alone, from idle
		foreach (srcs[k]) begin
			fire(17'h00001 << srcs[k]);
			waitTake(lvs[k]);
			if (lvs[k] == 3) chk("excLatency", n <= 2, 1'b1);
			ret(lvs[k]);
		end
		// General line latency and requeue while active
		fire(17'h00100);
		waitTake(8);
		chk("irqLatency", n >= 4, 1'b1);
		fire(17'h00100);
		ret(8);
		waitTake(8);
		ret(8);
		// Competing requests and preemption
		coreReady <= 1'b0;
		fire(17'h002a0);
		repeat (6) @(posedge clk);
		coreReady <= 1'b1;
		waitTake(5);
		ret(5);
		waitTake(7);
		fire(17'h00040);
		waitTake(6);
		chk("nestOut", nestOut, 16'h00c0);
		ret(6);
		ret(7);
		waitTake(9);
		ret(9);
		// Random groups of general requests, served lowest level first
		repeat (6) begin
			pick = $random(seed);
			coreReady <= 1'b0;
			fire({1'b0, pick, 7'h00});
			repeat (6) @(posedge clk);
			coreReady <= 1'b1;
			for (int l = 7; l < 16; l++) begin
				if (pick[l - 7]) begin
					waitTake(l);
					ret(l);
				end
			end
		end
		chk("nestOut", nestOut, 0);
		test_done;
	end
endmodule : testbench
